// file: verilog/sbg_map.svh
// Register map, field positions, reset values and timer counts of the baud generator
`ifndef SBG_MAP_SVH
`define SBG_MAP_SVH

// Word indexes on the Avalon-MM slave
`define SBG_IDX_BAUD_CTRL 3'h0
`define SBG_IDX_RX_STAT 3'h1
`define SBG_IDX_DIV_LOW 3'h2
`define SBG_IDX_DIV_HIGH 3'h3
`define SBG_IDX_TX_STAT 3'h4

// Field positions
`define SBG_BRC_WIDE_BIT 3
`define SBG_RSC_ENABLE_BIT 7
`define SBG_TXS_SYNC_BIT 4
`define SBG_TXS_HIGH_SPEED_BIT 2

// Writable bits of each control register
`define SBG_BRC_WMASK 8'h1b
`define SBG_RSC_WMASK 8'hf8
`define SBG_TXS_WMASK 8'hfd

// Reset values
`define SBG_BRC_RESET 8'h00
`define SBG_RSC_RESET 8'h00
`define SBG_TXS_RESET 8'h00
`define SBG_DIV_RESET 8'h00

// Prescaler terminal counts: multiplier minus one
`define SBG_PRE_ASYNC_SLOW8 6'h3f
`define SBG_PRE_ASYNC_MID 6'h0f
`define SBG_PRE_FAST 6'h03

`endif

// file: verilog/sbg_pkg.sv
// Types shared by the baud generator
`default_nettype none
package sbg_pkg;

    typedef enum logic {SBG_BUS_IDLE, SBG_BUS_ACK} sbg_bus_t;

    typedef logic [7:0] sbg_byte_t;

endpackage : sbg_pkg
`default_nettype wire

// file: verilog/sbg_top.sv
// Baud rate generator with its control registers on an Avalon-MM slave
//
// Notes on behaviour
// R1 - 8-bit timer after reset; 16-bit when wide
// R2 - Free-running timer; divisor bytes set period
// R3 - Async multiplier uses both bits; sync ignores high-speed
// R4 - Divisor write clears the timer at once
// R5 - Rates 64, 16 or 4 times (n+1)
// R6 - Async high speed: 16 narrow, 4 wide
// R7 - Software checks idle before changing clock
// R8 - Software prefers high speed or wide divider
// R9 - Mode bit set means synchronous operation
// R10 - Idle flag one when idle, zero receiving
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sbg_map.svh"

module sbg_top #(
    parameter int DIV_W = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic rx_active,
    input wire logic [2:0] rx_status,
    input wire logic abd_overflow,
    input wire logic tsr_empty,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic baud_tick,
    output logic sync_mode,
    output logic port_enable
);

    // =====================================================
    // Register bus
    // =====================================================
    sbg_pkg::sbg_bus_t bus_st_r;
    sbg_pkg::sbg_bus_t bus_st_nxt;
    logic wait_r;
    logic wait_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    sbg_pkg::sbg_byte_t brc_r;
    sbg_pkg::sbg_byte_t brc_nxt;
    sbg_pkg::sbg_byte_t rsc_r;
    sbg_pkg::sbg_byte_t rsc_nxt;
    sbg_pkg::sbg_byte_t txs_r;
    sbg_pkg::sbg_byte_t txs_nxt;
    sbg_pkg::sbg_byte_t div_lo_r;
    sbg_pkg::sbg_byte_t div_lo_nxt;
    sbg_pkg::sbg_byte_t div_hi_r;
    sbg_pkg::sbg_byte_t div_hi_nxt;
    logic idle_r;
    logic idle_nxt;
    logic commit;
    logic div_wr;
    sbg_pkg::sbg_byte_t rd_val;

    // A write lands only at the edge where waitrequest is seen low
    assign commit = (bus_st_r == sbg_pkg::SBG_BUS_ACK) && avs_write && avs_byteenable[0];

    always_comb
    begin
        rd_val = 8'h00;
        case (avs_address)
            `SBG_IDX_BAUD_CTRL: rd_val = (brc_r & `SBG_BRC_WMASK) | {abd_overflow, idle_r, 6'h00};
            `SBG_IDX_RX_STAT: rd_val = (rsc_r & `SBG_RSC_WMASK) | {5'h00, rx_status};
            `SBG_IDX_DIV_LOW: rd_val = div_lo_r;
            `SBG_IDX_DIV_HIGH: rd_val = div_hi_r;
            `SBG_IDX_TX_STAT: rd_val = (txs_r & `SBG_TXS_WMASK) | {6'h00, tsr_empty, 1'b0};
            default: rd_val = 8'h00;
        endcase
    end

    always_comb
    begin
        bus_st_nxt = bus_st_r;
        wait_nxt = wait_r;
        rdata_nxt = rdata_r;
        case (bus_st_r)
            sbg_pkg::SBG_BUS_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    bus_st_nxt = sbg_pkg::SBG_BUS_ACK;
                    wait_nxt = 1'b0;
                    rdata_nxt = {24'h000000, rd_val};
                end
            end
            sbg_pkg::SBG_BUS_ACK:
            begin
                bus_st_nxt = sbg_pkg::SBG_BUS_IDLE;
                wait_nxt = 1'b1;
            end
            default:
            begin
                bus_st_nxt = sbg_pkg::SBG_BUS_IDLE;
                wait_nxt = 1'b1;
            end
        endcase
    end

    always_comb
    begin
        brc_nxt = brc_r;
        rsc_nxt = rsc_r;
        txs_nxt = txs_r;
        div_lo_nxt = div_lo_r;
        div_hi_nxt = div_hi_r;
        div_wr = 1'b0;
        if (commit)
        begin
            case (avs_address)
                `SBG_IDX_BAUD_CTRL: brc_nxt = avs_writedata[7:0] & `SBG_BRC_WMASK;
                `SBG_IDX_RX_STAT: rsc_nxt = avs_writedata[7:0] & `SBG_RSC_WMASK;
                `SBG_IDX_TX_STAT: txs_nxt = avs_writedata[7:0] & `SBG_TXS_WMASK;
                `SBG_IDX_DIV_LOW:
                begin
                    div_lo_nxt = avs_writedata[7:0];
                    div_wr = 1'b1; // R4
                end
                `SBG_IDX_DIV_HIGH:
                begin
                    div_hi_nxt = avs_writedata[7:0];
                    div_wr = 1'b1; // R4
                end
                default: div_wr = 1'b0;
            endcase
        end
        // Registered so the read path never sees rx_active directly
        idle_nxt = ~rx_active; // R10
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_st_r <= sbg_pkg::SBG_BUS_IDLE;
            wait_r <= 1'b1;
            rdata_r <= 32'h00000000;
            brc_r <= `SBG_BRC_RESET;
            rsc_r <= `SBG_RSC_RESET;
            txs_r <= `SBG_TXS_RESET;
            div_lo_r <= `SBG_DIV_RESET;
            div_hi_r <= `SBG_DIV_RESET;
            idle_r <= 1'b1;
        end
        else if (ce)
        begin
            bus_st_r <= bus_st_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
            brc_r <= brc_nxt;
            rsc_r <= rsc_nxt;
            txs_r <= txs_nxt;
            div_lo_r <= div_lo_nxt;
            div_hi_r <= div_hi_nxt;
            idle_r <= idle_nxt;
        end
    end

    // =====================================================
    // Baud timer
    // =====================================================
    logic [5:0] pre_r;
    logic [5:0] pre_nxt;
    logic [5:0] pre_max;
    logic [DIV_W-1:0] tmr_r;
    logic [DIV_W-1:0] tmr_nxt;
    logic [DIV_W-1:0] div_n;
    logic tick_r;
    logic tick_nxt;
    logic wide;
    logic fast;
    logic is_sync;
    logic spen;

    assign wide = brc_r[`SBG_BRC_WIDE_BIT]; // R1
    assign fast = txs_r[`SBG_TXS_HIGH_SPEED_BIT];
    assign is_sync = txs_r[`SBG_TXS_SYNC_BIT]; // R9
    assign spen = rsc_r[`SBG_RSC_ENABLE_BIT];

    // Narrow mode leaves the high byte out of the divisor; a write to it still restarts the timer
    assign div_n = wide ? DIV_W'({div_hi_r, div_lo_r}) : DIV_W'(div_lo_r); // R1

    always_comb
    begin
        if (is_sync)
        begin
            pre_max = `SBG_PRE_FAST; // R3 R5
        end
        else
        begin
            case ({wide, fast})
                2'b00: pre_max = `SBG_PRE_ASYNC_SLOW8; // R5
                2'b01: pre_max = `SBG_PRE_ASYNC_MID; // R6
                2'b10: pre_max = `SBG_PRE_ASYNC_MID; // R5
                2'b11: pre_max = `SBG_PRE_FAST; // R6
                default: pre_max = `SBG_PRE_ASYNC_SLOW8;
            endcase
        end
    end

    // Period is (pre_max+1)*(n+1) clocks; one tick per period
    always_comb
    begin
        pre_nxt = pre_r;
        tmr_nxt = tmr_r;
        tick_nxt = 1'b0;
        if (!spen || div_wr)
        begin
            // Held cleared while the port is disabled; restart on a new divisor
            pre_nxt = 6'h00; // R4
            tmr_nxt = '0; // R4
        end
        else if (pre_r >= pre_max)
        begin
            pre_nxt = 6'h00;
            if (tmr_r >= div_n)
            begin
                tmr_nxt = '0; // R2
                tick_nxt = 1'b1; // R2
            end
            else
            begin
                tmr_nxt = tmr_r + 1'b1;
            end
        end
        else
        begin
            pre_nxt = pre_r + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pre_r <= 6'h00;
            tmr_r <= '0;
            tick_r <= 1'b0;
        end
        else if (ce)
        begin
            pre_r <= pre_nxt;
            tmr_r <= tmr_nxt;
            tick_r <= tick_nxt;
        end
    end

    // =====================================================
    // Outputs
    // =====================================================
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign baud_tick = tick_r;
    assign sync_mode = txs_r[`SBG_TXS_SYNC_BIT];
    assign port_enable = rsc_r[`SBG_RSC_ENABLE_BIT];

endmodule : sbg_top
`default_nettype wire

// file: dv/sbg_chk_asserts.sv
// Port assertions of the baud generator
`timescale 1ns/1ps
`default_nettype none
module sbg_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [3:0] avs_byteenable,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic rx_active,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic baud_tick,
    input wire logic sync_mode,
    input wire logic port_enable
);
    // ====
    // Shadow of the written settings
    logic [7:0] reg_r [8];
    logic [31:0] gap_r, w_r, per;
    logic ok_r, first_r, wr;
    // A write lands only with the clock enabled and the low byte lane on
    assign wr = avs_write && !avs_waitrequest && ce && avs_byteenable[0];
    assign per = (reg_r[4][4] ? 4 : reg_r[0][3] ^ reg_r[4][2] ? 16 : reg_r[0][3] ? 4 : 64)
        * ((reg_r[0][3] ? {reg_r[3], reg_r[2]} : reg_r[2]) + 1);
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_r <= '{default: 8'h0};
            {gap_r, w_r, ok_r, first_r} <= 66'h0;
        end
        else if (ce)
        begin
            // Frozen edges are not counted, as the design does not count them
            gap_r <= baud_tick ? 32'h1 : gap_r + 32'h1;
            w_r <= wr && avs_address[2:1] == 2'h1 ? 32'h1 : w_r + 32'h1;
            // A tick at the write edge still comes from the old count
            ok_r <= (ok_r || (baud_tick && w_r > 1)) && !wr && port_enable;
            first_r <= (wr && avs_address[2:1] == 2'h1)
                || (first_r && !(baud_tick && w_r > 1) && port_enable);
            if (wr)
                reg_r[avs_address] <= avs_writedata[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n || !ce);
    a_tick_single: assert property (baud_tick |=> !baud_tick)
        else $error("long tick");
    a_gap_exact: assert property (baud_tick && ok_r |-> gap_r == per)
        else $error("bad period");
    a_restart_tick: assert property (baud_tick && first_r && w_r > 1 |->
        w_r >= per && w_r <= per + 2) else $error("bad restart");
    a_idle_stop: assert property (!port_enable [*2] |-> !baud_tick)
        else $error("tick while off");
    a_mode_follow: assert property (wr && avs_address == 3'h4 |->
        ##2 sync_mode == $past(avs_writedata[4], 2)) else $error("bad mode");
    a_port_follow: assert property (wr && avs_address == 3'h1 |->
        ##2 port_enable == $past(avs_writedata[7], 2)) else $error("bad enable");
    a_idle_read: assert property (avs_read && !avs_waitrequest && !avs_address
        && $stable(rx_active) && $past(rx_active, 2) == rx_active
        |-> avs_readdata[6] == !rx_active) else $error("bad idle");
    a_bus_ack: assert property ($rose(avs_read || avs_write) |-> ##1 !avs_waitrequest)
        else $error("late ack");
    c_gap: cover property (baud_tick && ok_r && sync_mode);
    c_restart: cover property (baud_tick && first_r);
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule : sbg_chk
bind sbg_top sbg_chk chk_u (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .avs_byteenable(avs_byteenable),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .rx_active(rx_active),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .baud_tick(baud_tick),
    .sync_mode(sync_mode),
    .port_enable(port_enable)
);
`default_nettype wire

// file: dv/tb_top.sv
// Bench of the baud generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, arst_n, ce, avs_read, avs_write, rx_active, abd_overflow, tsr_empty;
    logic [3:0] avs_byteenable;
    logic avs_waitrequest, baud_tick, sync_mode, port_enable;
    logic [2:0] avs_address, rx_status;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [63:0] rows [8];
    int mismatches, comparisons, i, c, t, k;
    sbg_top dut_u (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .rx_active(rx_active),
        .rx_status(rx_status),
        .abd_overflow(abd_overflow),
        .tsr_empty(tsr_empty),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .baud_tick(baud_tick),
        .sync_mode(sync_mode),
        .port_enable(port_enable)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t %h %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        if (mismatches == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    task automatic guard(input logic ok);
        if (ok !== 1'b1)
        begin
            mismatches++;
            final_report();
        end
    endtask : guard
    // ====
    // One idle edge first, so a request is never dropped and raised together
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 20);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        guard(!avs_waitrequest);
    endtask : bus
    task automatic wait_tick(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (baud_tick !== 1'b1 && n < 9000);
        guard(baud_tick);
    endtask : wait_tick
    initial
    begin
        clk = 1'b0;
        forever
            #12.5 clk = ~clk;
    end
    initial
    begin
        // Period, transmit control, baud control, divisor high, divisor low
        rows = '{64'h4_10000000, 64'hc_14000502, 64'h404_10080100, 64'h80_00000701,
            64'h30_04000002, 64'h1020_00080101, 64'h18_04080005, 64'h40_00000000};
        {arst_n, avs_read, avs_write, rx_active} = 4'h0;
        ce = 1'b1;
        avs_byteenable = 4'h1;
        avs_address = 3'h0;
        avs_writedata = 32'h0;
        {rx_status, abd_overflow, tsr_empty} = 5'h17;
        repeat (12)
            @(posedge clk);
        arst_n <= 1'b1;
        check({baud_tick, sync_mode, port_enable}, 3'h0);
        bus(1, 3'h7, 8'hff);
        for (i = 0; i < 8; i++)
        begin
            bus(0, i[2:0], 8'h0);
            check(q, 32'(64'h2000005c0 >> i * 8 & 64'hff));
        end
        bus(1, 3'h1, 8'h80);
        for (i = 0; i < 8; i++)
        begin
            bus(1, 3'h4, rows[i][31:24]);
            bus(1, 3'h0, rows[i][23:16]);
            bus(1, 3'h3, rows[i][15:8]);
            bus(1, 3'h2, rows[i][7:0]);
            wait_tick(c);
            check(c >= rows[i][63:32] && c <= rows[i][63:32] + 2, 1'b1);
            wait_tick(t);
            check(t, rows[i][63:32]);
            check(sync_mode, rows[i][28]);
        end
        // Frozen clock enable stretches the period by exactly the frozen edges
        ce <= 1'b0;
        repeat (5)
            @(posedge clk);
        ce <= 1'b1;
        wait_tick(t);
        check(t, rows[7][63:32]);
        // A write without the low byte lane is refused and must leave the divisor low byte unchanged
        avs_byteenable <= 4'h0;
        bus(1, 3'h2, 8'h55);
        avs_byteenable <= 4'h1;
        bus(0, 3'h2, 8'h0);
        check(q, 32'h0);
        rx_active <= 1'b1;
        bus(0, 3'h0, 8'h0);
        bus(0, 3'h0, 8'h0);
        check(q[6], 1'b0);
        bus(1, 3'h1, 8'h0);
        repeat (2)
            @(posedge clk);
        c = 0;
        repeat (300)
        begin
            @(posedge clk);
            c += baud_tick;
        end
        check({c[7:0], port_enable}, 9'h0);
        // Reset in mid-run must bring the transmit and receive control settings back
        bus(1, 3'h4, 8'h10);
        bus(1, 3'h1, 8'h80);
        arst_n <= 1'b0;
        @(posedge clk);
        check({baud_tick, sync_mode, port_enable, avs_waitrequest}, 4'h1);
        check(avs_readdata, 32'h0);
        arst_n <= 1'b1;
        bus(0, 3'h4, 8'h0);
        check(q, 32'h2);
        bus(0, 3'h1, 8'h0);
        check(q, 32'h5);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
